// ===== rtl/wkc_defs.vh
// register offsets, field positions and reset values of the wake-up controller
// What this block does
// - config holds rc osc enable, crystal enable, clock select (1 rc, 0 crystal).
// - config bit keeps retention ram powered in sleep when set, unpowered when cleared.
// - arm bit set lets a timeout wake the chip; cleared, timeouts never wake.
// - reload high byte takes effect only once the low byte is written.
// - timer decrements per prescaler tick; wake event fires when enabled and zero.
// - control bit enables rc oscillator calibration when set.
// - writing 1 to flag-clear clears latched timeout and cold-start flags.
// - status bit shows calibration ended with error, valid with calibration on.
// - status bit shows calibration finished, zero while in progress.
// - status bit shows crystal oscillator settled, valid while it is enabled.
// - status bit mirrors the live crystal oscillator output level.
// - cold-start flag stays set until cleared by flag-clear.
// - timeout flag latches on timeout and holds until flag-clear.
// - live status bit is one only while the counter is zero.
`ifndef WKC_DEFS_VH
`define WKC_DEFS_VH
`define WKC_ADDR_W 10
`define WKC_OFS_CFG_HIGH 10'h30c
`define WKC_OFS_CFG_LOW 10'h30d
`define WKC_OFS_RELOAD_HIGH 10'h30e
`define WKC_OFS_RELOAD_LOW 10'h30f
`define WKC_OFS_FLAG_CLR 10'h310
`define WKC_OFS_STATUS 10'h311
`define WKC_OFS_IRQ_CLR 10'h340
`define WKC_OFS_IRQ_EN 10'h341
`define WKC_OFS_IRQ_STAT 10'h342
`define WKC_CFG_RC_EN 6
`define WKC_CFG_XT_EN 5
`define WKC_CFG_CLKSEL 4
`define WKC_CFG_RAM_EN 3
`define WKC_CFG_ARM 0
`define WKC_FC_CAL_EN 1
`define WKC_FC_CLR 0
`define WKC_ST_CAL_ERR 6
`define WKC_ST_CAL_DONE 5
`define WKC_ST_XT_RDY 4
`define WKC_ST_XT_OUT 3
`define WKC_ST_COLD 2
`define WKC_ST_TO_FLAG 1
`define WKC_ST_TO_LIVE 0
`define WKC_IRQ_TIMEOUT 0
`define WKC_IRQ_WAKE 1
`define WKC_IRQ_CAL_DONE 2
`define WKC_RST_BYTE 8'h00
`endif

// ===== rtl/wkc_wake_up_controller.v
// wake-up controller: config, reload, prescaled 16-bit down timer, status, interrupt
`timescale 1ns/1ps
`include "wkc_defs.vh"
module wkc_wake_up_controller (
  input wire clk,
  input wire rst,
  input wire [9:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire rc_osc_32k_a,
  input wire xtal_osc_32k,
  input wire xtal32_settled_in,
  input wire rc_cal_done_in,
  input wire rc_cal_error_in,
  input wire cold_start_in,
  output reg rc_osc_enable,
  output reg xtal32_enable,
  output reg rc_cal_enable,
  output reg retention_ram_power_enable,
  output reg wake_request,
  output reg irq
);
  // register state
  reg [7:0] cfg_high_q;
  reg [7:0] cfg_low_q;
  reg [7:0] reload_hi_stage_q;
  reg [15:0] wake_timer_reload_q;
  reg rc_cal_enable_q;
  reg cold_q;
  reg to_flag_q;
  reg [15:0] count_q;
  reg [15:0] pre_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_en_q;
  // three-stage synchronisers for the asynchronous oscillator and analog inputs
  reg [2:0] rc_s_q;
  reg [2:0] xt_s_q;
  reg [2:0] xrdy_s_q;
  reg [2:0] cdone_s_q;
  reg [2:0] cerr_s_q;
  reg [2:0] cold_s_q;
  reg rc_f_q;
  reg xt_f_q;
  reg xrdy_f_q;
  reg cdone_f_q;
  reg cerr_f_q;
  reg cold_f_q;
  reg src_prev_q;
  reg cdone_prev_q;

  wire wr_cfg_low = wr && (addr == `WKC_OFS_CFG_LOW);
  wire wr_cfg_high = wr && (addr == `WKC_OFS_CFG_HIGH);
  wire wr_rel_hi = wr && (addr == `WKC_OFS_RELOAD_HIGH);
  wire wr_rel_lo = wr && (addr == `WKC_OFS_RELOAD_LOW);
  wire wr_fc = wr && (addr == `WKC_OFS_FLAG_CLR);
  wire flag_clr = wr_fc && wdata[`WKC_FC_CLR];

  // filtered level changes once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      rc_s_q <= 3'h0;
      xt_s_q <= 3'h0;
      xrdy_s_q <= 3'h0;
      cdone_s_q <= 3'h0;
      cerr_s_q <= 3'h0;
      cold_s_q <= 3'h0;
      rc_f_q <= 1'b0;
      xt_f_q <= 1'b0;
      xrdy_f_q <= 1'b0;
      cdone_f_q <= 1'b0;
      cerr_f_q <= 1'b0;
      cold_f_q <= 1'b0;
    end else begin
      rc_s_q <= {rc_s_q[1:0], rc_osc_32k_a};
      xt_s_q <= {xt_s_q[1:0], xtal_osc_32k};
      xrdy_s_q <= {xrdy_s_q[1:0], xtal32_settled_in};
      cdone_s_q <= {cdone_s_q[1:0], rc_cal_done_in};
      cerr_s_q <= {cerr_s_q[1:0], rc_cal_error_in};
      cold_s_q <= {cold_s_q[1:0], cold_start_in};
      if (rc_s_q[2] == rc_s_q[1]) rc_f_q <= rc_s_q[2];
      if (xt_s_q[2] == xt_s_q[1]) xt_f_q <= xt_s_q[2];
      if (xrdy_s_q[2] == xrdy_s_q[1]) xrdy_f_q <= xrdy_s_q[2];
      if (cdone_s_q[2] == cdone_s_q[1]) cdone_f_q <= cdone_s_q[2];
      if (cerr_s_q[2] == cerr_s_q[1]) cerr_f_q <= cerr_s_q[2];
      if (cold_s_q[2] == cold_s_q[1]) cold_f_q <= cold_s_q[2];
    end
  end

  // selected 32 kHz source, rising edge gives one slow tick
  wire src_lvl = cfg_low_q[`WKC_CFG_CLKSEL] ? rc_f_q : xt_f_q;
  wire src_on = cfg_low_q[`WKC_CFG_CLKSEL] ? cfg_low_q[`WKC_CFG_RC_EN]
                                           : cfg_low_q[`WKC_CFG_XT_EN];
  wire slow_tick = src_lvl && !src_prev_q && src_on;

  // prescaler divide selects the timer tick
  reg [15:0] pre_last;
  always @* begin
    case (cfg_high_q[2:0])
      3'h0: pre_last = 16'h0000;
      3'h1: pre_last = 16'h0003;
      3'h2: pre_last = 16'h0007;
      3'h3: pre_last = 16'h000f;
      3'h4: pre_last = 16'h007f;
      3'h5: pre_last = 16'h03ff;
      3'h6: pre_last = 16'h1fff;
      default: pre_last = 16'hffff;
    endcase
  end
  wire tmr_tick = slow_tick && (pre_q >= pre_last);
  wire at_zero = (count_q == 16'h0000);
  wire timeout = tmr_tick && (count_q == 16'h0001);
  wire cdone_rise = cdone_f_q && !cdone_prev_q && rc_cal_enable_q;

  // register writes and config
  always @(posedge clk) begin
    if (rst) begin
      cfg_high_q <= `WKC_RST_BYTE;
      cfg_low_q <= `WKC_RST_BYTE;
      reload_hi_stage_q <= `WKC_RST_BYTE;
      wake_timer_reload_q <= 16'h0000;
      rc_cal_enable_q <= 1'b0;
      irq_en_q <= 3'h0;
    end else begin
      if (wr_cfg_high) cfg_high_q <= wdata;
      if (wr_cfg_low) cfg_low_q <= wdata & 8'h79; // reserved bits kept zero
      if (wr_rel_hi) reload_hi_stage_q <= wdata; // staged only
      if (wr_rel_lo) wake_timer_reload_q <= {reload_hi_stage_q, wdata};
      if (wr_fc) rc_cal_enable_q <= wdata[`WKC_FC_CAL_EN];
      if (wr && addr == `WKC_OFS_IRQ_EN) irq_en_q <= wdata[2:0];
    end
  end

  // prescaler and down counter with reload on expiry
  always @(posedge clk) begin
    if (rst) begin
      pre_q <= 16'h0000;
      count_q <= 16'h0000;
      src_prev_q <= 1'b0;
      cdone_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_lvl;
      cdone_prev_q <= cdone_f_q;
      if (wr_rel_lo) begin
        count_q <= {reload_hi_stage_q, wdata};
        pre_q <= 16'h0000;
      end else if (tmr_tick) begin
        pre_q <= 16'h0000;
        if (at_zero) count_q <= wake_timer_reload_q;
        else count_q <= count_q - 16'h0001;
      end else if (slow_tick) begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // sticky flags, set wins over clear
  always @(posedge clk) begin
    if (rst) begin
      cold_q <= 1'b0;
      to_flag_q <= 1'b0;
      irq_stat_q <= 3'h0;
    end else begin
      if (cold_f_q) cold_q <= 1'b1;
      else if (flag_clr) cold_q <= 1'b0;
      if (timeout) to_flag_q <= 1'b1;
      else if (flag_clr) to_flag_q <= 1'b0;
      irq_stat_q <= (irq_stat_q & ~((wr && addr == `WKC_OFS_IRQ_CLR) ? wdata[2:0] : 3'h0))
                    | {cdone_rise, timeout && cfg_low_q[`WKC_CFG_ARM], timeout};
    end
  end

  // outputs one cycle behind their registers, read data one cycle after the strobe
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rc_osc_enable <= 1'b0;
      xtal32_enable <= 1'b0;
      rc_cal_enable <= 1'b0;
      retention_ram_power_enable <= 1'b0;
      wake_request <= 1'b0;
      irq <= 1'b0;
    end else begin
      rc_osc_enable <= cfg_low_q[`WKC_CFG_RC_EN];
      xtal32_enable <= cfg_low_q[`WKC_CFG_XT_EN];
      rc_cal_enable <= rc_cal_enable_q;
      retention_ram_power_enable <= cfg_low_q[`WKC_CFG_RAM_EN];
      wake_request <= timeout && cfg_low_q[`WKC_CFG_ARM];
      irq <= |(irq_stat_q & irq_en_q);
      if (rd) begin
        case (addr)
          `WKC_OFS_FLAG_CLR: rdata <= {6'h00, rc_cal_enable_q, 1'b0};
          `WKC_OFS_STATUS: rdata <= {1'b0,
            cerr_f_q && rc_cal_enable_q,
            cdone_f_q && rc_cal_enable_q,
            xrdy_f_q && cfg_low_q[`WKC_CFG_XT_EN],
            xt_f_q,
            cold_q, to_flag_q,
            at_zero};
          `WKC_OFS_IRQ_EN: rdata <= {5'h00, irq_en_q};
          `WKC_OFS_IRQ_STAT: rdata <= {5'h00, irq_stat_q};
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end
endmodule // wkc_wake_up_controller

// ===== tb/wkc_chk.sv
// port assertions of the wake-up controller
`timescale 1ns/1ps
module wkc_chk (
  input wire clk,
  input wire rst,
  input wire [9:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire rc_osc_enable,
  input wire xtal32_enable,
  input wire rc_cal_enable,
  input wire retention_ram_power_enable,
  input wire wake_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // write strobe aimed at the config register and read strobe of the status register
  wire cfg_wr = wr && addr == 10'h30d;
  wire st_rd = rd && addr == 10'h311;
  rd_slot_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside slot");
  // enables follow the register one cycle after it is written, two after the strobe
  rc_en_a: assert property (cfg_wr |-> ##2 rc_osc_enable == $past(wdata[6], 2))
    else $error("rc enable wrong");
  xt_en_a: assert property (cfg_wr |-> ##2 xtal32_enable == $past(wdata[5], 2))
    else $error("crystal enable wrong");
  ram_pwr_a: assert property (cfg_wr |-> ##2 retention_ram_power_enable == $past(wdata[3], 2))
    else $error("ram power wrong");
  cfg_hold_a: assert property (!cfg_wr ##1 !cfg_wr |=> $stable({rc_osc_enable,
    xtal32_enable, retention_ram_power_enable})) else $error("config outputs moved");
  cal_en_a: assert property (wr && addr == 10'h310 |-> ##2 rc_cal_enable == $past(wdata[1], 2))
    else $error("cal enable wrong");
  cal_gate_a: assert property (st_rd && !rc_cal_enable |=> rdata[6:5] == 2'b00)
    else $error("cal status shown while off");
  xt_gate_a: assert property (st_rd && !xtal32_enable |=> rdata[4] == 1'b0)
    else $error("settled shown while off");
  wake_pulse_a: assert property (wake_request |=> !wake_request)
    else $error("wake request too long");
endmodule // wkc_chk
bind wkc_wake_up_controller wkc_chk chk_u (.*);

// ===== tb/tb_wakeup_timer_control.sv
// self-checking bench of the wake-up controller
`timescale 1ns/1ps
module tb_wakeup_timer_control;
  reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rco = 1'b0, xto = 1'b0, xsi = 1'b0;
  reg cdi = 1'b0, cei = 1'b0, csi = 1'b1, cal = 1'b0, xt = 1'b0, cold = 1'b1, flag = 1'b0;
  reg live = 1'b1;
  reg [9:0] addr = 10'h000;
  reg [7:0] wdata = 8'h00;
  reg [31:0] seed = 32'h00000022;
  wire [7:0] rdata;
  wire rc_en, xt_en, cal_en, ram_en, wake, irq;
  integer fail_count = 0, n_compared = 0, cyc = 0, wakes = 0, i;
  wkc_wake_up_controller DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rc_osc_32k_a(rco), .xtal_osc_32k(xto),
    .xtal32_settled_in(xsi), .rc_cal_done_in(cdi), .rc_cal_error_in(cei),
    .cold_start_in(csi), .rc_osc_enable(rc_en), .xtal32_enable(xt_en),
    .rc_cal_enable(cal_en), .retention_ram_power_enable(ram_en),
    .wake_request(wake), .irq(irq));
  always #10 clk = ~clk;
  // cycle ceiling and wake pulse count
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (wake === 1'b1) wakes = wakes + 1;
    if (cyc == 6000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  function [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction
  // expected status byte from the model
  function [7:0] st;
    st = {1'b0, cal & cei, cal & cdi, xt & xsi, xto, cold, flag, live};
  endfunction
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_t(logic [9:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_t(logic [9:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, e);
  endtask
  task automatic irq_is(logic e);
    repeat (2) @(posedge clk);
    #1 chk("irq", {7'h00, irq}, {7'h00, e});
  endtask
  // one rising edge of the rc source, then settle time
  task pulse;
    repeat (8) @(posedge clk);
    rco <= 1'b1;
    repeat (8) @(posedge clk);
    rco <= 1'b0;
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rd_t(10'h311, st());
    csi <= 1'b0;
    repeat (5) @(posedge clk);
    wr_t(10'h310, 8'h01);
    cold = 1'b0;
    rd_t(10'h311, st());
    rd_t(10'h3ff, 8'h00);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr_t(10'h30c, 8'h00);
      wr_t(10'h30d, seed[7:0] & 8'h68);
      repeat (2) @(negedge clk);
      chk("cfg", {5'h00, rc_en, xt_en, ram_en}, {5'h00, seed[6], seed[5], seed[3]});
    end
    wr_t(10'h30d, 8'h20);
    xt = 1'b1;
    wr_t(10'h310, 8'h02);
    cal = 1'b1;
    cdi <= 1'b1;
    cei <= 1'b1;
    xsi <= 1'b1;
    xto <= 1'b1;
    repeat (6) @(posedge clk);
    rd_t(10'h311, st());
    rd_t(10'h310, 8'h02);
    wr_t(10'h310, 8'h00);
    cal = 1'b0;
    xto <= 1'b0;
    repeat (6) @(posedge clk);
    rd_t(10'h311, st());
    wr_t(10'h340, 8'h07);
    wr_t(10'h341, 8'h03);
    wr_t(10'h30e, 8'h00);
    wr_t(10'h30f, 8'h02);
    wr_t(10'h30d, 8'h51);
    xt = 1'b0;
    live = 1'b0;
    for (i = 1; i <= 8; i++) begin
      pulse;
      if (i == 2) wr_t(10'h30e, 8'h01);
      if (i == 5) wr_t(10'h30d, 8'h50);
      if (i == 6) wr_t(10'h310, 8'h01);
      if (i == 6) flag = 1'b0;
      live = (i % 3 == 2);
      flag = flag | live;
      rd_t(10'h311, st());
      chk("wakes", wakes[7:0], 8'd0 + (i >= 2) + (i >= 5));
    end
    rd_t(10'h342, 8'h03);
    irq_is(1'b1);
    wr_t(10'h341, 8'h00);
    irq_is(1'b0);
    wr_t(10'h340, 8'h03);
    rd_t(10'h342, 8'h00);
    conclude;
  end
endmodule // tb_wakeup_timer_control
